// ---- rtl/contactless_error_flags.sv ----
// error flag logic of the contactless transceiver with an axi4-lite register slave
// assumes all event inputs synchronous to sys_clk and held stable under clkEn low
//
// Behaviour
// - nvm error flag follows the outcome of the last nvm command
// - fifo write during crc, receive states or authentication sets write violation
// - write violation flag clears when a new command starts
// - with multi-frame receive, write violation clears after flags appended to fifo
// - write into a full fifo sets the overflow flag
// - after overflow, fifo contents kept and every later write discarded
// - valid start of frame followed by under four bits sets short frame error
// - frames under four bits dropped, decoder stays on, no receive-done
// - with disturbance suppression, frames under three bytes get same treatment
// - receive start or transceive wait-for-data entry clears four receive error flags
// - transmission requested with empty fifo sets the empty transmit error
// - bit collision sets collision flag and records first collision position
// - collision inside the end-of-frame symbol does not set the collision flag
// - wrong stop bit, type-b frame delimiters or byte count set protocol error
// - protocol error stops data reception at once
// - on protocol error the last received byte is not stored
// - parity or crc mismatch sets integrity error, reception goes on
// - with collision-as-error set, a collision also sets integrity error
// - error interrupt flag raised when write violation, overflow, empty transmit, protocol or integrity flag becomes set
// - all eight flags in one register at index 0ah, hardware updated
`timescale 1ns/1ps
`include "contactless_error_cfg.svh"
module contactless_error_flags (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transceiver side
    input wire logic [2:0] comState,
    input wire contactless_error_pkg::cmd_event_s cmdEvent,
    input wire contactless_error_pkg::rx_event_s rxEvent,
    input wire logic fifoWrite,
    input wire logic fifoFull,
    input wire logic fifoEmpty,
    input wire logic fifoFlush,
    input wire logic flagsAppended,
    output logic [7:0] errorFlags,
    output logic fifoWriteBlock,
    output logic fifoStore,
    output logic receiveDecoderEnable,
    output logic receiveStop,
    output logic receiveDoneInterrupt,
    output logic frameDiscard,
    output logic errorInterruptFlag
);

    // ------------------------------------------------------------
    // registers and event decode
    // ------------------------------------------------------------
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] ctrl_reg;
    logic [7:0] collPos_reg;
    logic [2:0] prevState_reg;
    logic decoderOn_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [7:0] setMask;
    logic [7:0] clrMask;
    logic inRxState;
    logic rxPhaseStart;
    logic shortBits;
    logic shortSuppressed;
    logic discard;
    logic protEvent;
    logic collCounted;
    logic wrDo;
    logic [7:0] wrIdx;
    logic [7:0] rdIdx;

    // receive states in which the fifo belongs to the receiver
    assign inRxState = (comState == `ST_RX_WAIT) || (comState == `ST_WAIT_DATA)
        || (comState == `ST_RECEIVING);
    // receive phase start: receive command, or transceive entering wait-for-data
    assign rxPhaseStart = cmdEvent.recvCmdStart || (cmdEvent.transceiveCmd
        && (comState == `ST_WAIT_DATA) && (prevState_reg != `ST_WAIT_DATA));
    assign shortBits = rxEvent.frameEnd && rxEvent.sofValid
        && (rxEvent.bitCount < `MIN_FRAME_BITS);
    // byte count is bits over eight; truncation here is on purpose
    assign shortSuppressed = rxEvent.frameEnd && ctrl_reg[`CTRL_SUPPRESS]
        && ({3'h0, rxEvent.bitCount[15:3]} < `MIN_SUPP_BYTES);
    assign discard = shortBits || shortSuppressed;
    assign protEvent = rxEvent.stopBitError || rxEvent.sofEofError
        || rxEvent.byteCountError;
    // a collision inside the end-of-frame symbol is not counted at all
    assign collCounted = rxEvent.collision && !rxEvent.collisionInEof;

    // ------------------------------------------------------------
    // flag set and clear masks
    // ------------------------------------------------------------
    // set terms of each flag; nvm flag is handled as a follow-the-result bit
    always_comb begin
        setMask = 8'h00;
        setMask[`BIT_FIFO_WR] = fifoWrite && (cmdEvent.crcTxActive || inRxState
            || cmdEvent.authActive);
        setMask[`BIT_FIFO_OVL] = fifoWrite && fifoFull;
        setMask[`BIT_SHORT] = shortBits;
        setMask[`BIT_EMPTY_TX] = cmdEvent.txStart && fifoEmpty;
        setMask[`BIT_COLL] = collCounted;
        setMask[`BIT_PROT] = protEvent;
        setMask[`BIT_INTEG] = rxEvent.parityError || rxEvent.crcError
            || (collCounted && ctrl_reg[`CTRL_COLL_ERR]);
    end

    // clear terms; with multi-frame receive the write flag waits for the append
    always_comb begin
        clrMask = 8'h00;
        if (ctrl_reg[`CTRL_MULTI]) begin
            clrMask[`BIT_FIFO_WR] = flagsAppended;
        end else begin
            clrMask[`BIT_FIFO_WR] = cmdEvent.cmdStart;
        end
        clrMask[`BIT_FIFO_OVL] = fifoFlush;
        clrMask[`BIT_EMPTY_TX] = cmdEvent.cmdStart;
        clrMask[`BIT_SHORT] = rxPhaseStart;
        clrMask[`BIT_COLL] = rxPhaseStart;
        clrMask[`BIT_PROT] = rxPhaseStart;
        clrMask[`BIT_INTEG] = rxPhaseStart;
    end

    // set wins over clear so an event in the clearing cycle is kept
    always_comb begin
        flags_next = (flags_reg & ~clrMask) | setMask;
        if (cmdEvent.nvmCmdDone) begin
            flags_next[`BIT_NVM] = cmdEvent.nvmCmdFail;
        end
    end

    // ------------------------------------------------------------
    // flag and receive control state
    // ------------------------------------------------------------
    // flags change only through hardware events, never by bus writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_reg <= `FLAGS_RESET;
        end else if (clkEn) begin
            flags_reg <= flags_next;
        end
    end

    // first collision position kept until the receive phase restarts;
    // a collision in the restart cycle is the first one of the new phase,
    // so the recorded position never disagrees with the surviving flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            collPos_reg <= 8'h00;
        end else if (clkEn) begin
            if (collCounted && (!flags_reg[`BIT_COLL] || rxPhaseStart)) begin
                collPos_reg <= {1'b1, rxEvent.collisionPos};
            end else if (rxPhaseStart) begin
                collPos_reg <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prevState_reg <= 3'h0;
        end else if (clkEn) begin
            prevState_reg <= comState;
        end
    end

    // decoder stays on across discarded frames, stops on protocol error
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            decoderOn_reg <= 1'b0;
        end else if (clkEn) begin
            if (protEvent) begin
                decoderOn_reg <= 1'b0;
            end else if (rxPhaseStart) begin
                decoderOn_reg <= 1'b1;
            end else if (rxEvent.frameEnd && !discard) begin
                decoderOn_reg <= 1'b0;
            end
        end
    end

    // registered strobes towards the datapath, one cycle behind the event
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fifoStore <= 1'b0;
            receiveStop <= 1'b0;
            receiveDoneInterrupt <= 1'b0;
            frameDiscard <= 1'b0;
            errorInterruptFlag <= 1'b0;
        end else if (clkEn) begin
            fifoStore <= rxEvent.byteReady && decoderOn_reg && !protEvent;
            receiveStop <= protEvent;
            receiveDoneInterrupt <= rxEvent.frameEnd && decoderOn_reg && !discard;
            frameDiscard <= rxEvent.frameEnd && discard;
            errorInterruptFlag <= |(setMask & ~flags_reg & 8'h6b);
        end
    end

    // fifo side copies of flags; the block is the overflow flag itself
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            errorFlags <= `FLAGS_RESET;
            fifoWriteBlock <= 1'b0;
            receiveDecoderEnable <= 1'b0;
        end else if (clkEn) begin
            errorFlags <= flags_next;
            fifoWriteBlock <= flags_next[`BIT_FIFO_OVL];
            receiveDecoderEnable <= decoderOn_reg;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    // address and data are taken in either order and held until both are in
    assign wrDo = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrIdx = {2'h0, awAddr_reg[7:2]};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wrDo) begin
                awHeld_reg <= 1'b0;
            end else if (!awHeld_reg) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wrDo) begin
                wHeld_reg <= 1'b0;
            end else if (!wHeld_reg) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // only the control register is writable; flag and position writes are dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (clkEn) begin
            if (wrDo && (wrIdx == `ERR_CTRL_IDX) && wStrb_reg[0]) begin
                ctrl_reg <= wData_reg[7:0] & 8'h0b;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (clkEn) begin
            if (wrDo) begin
                s_axi_bvalid <= 1'b1;
                if ((wrIdx == `ERR_CTRL_IDX) || (wrIdx == `ERR_FLAGS_IDX)
                    || (wrIdx == `COLL_POS_IDX)) begin
                    s_axi_bresp <= `RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RESP_DECERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    // one read at a time; arready drops while the answer waits
    assign rdIdx = {2'h0, s_axi_araddr[7:2]};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (rdIdx == `ERR_FLAGS_IDX) begin
                    s_axi_rdata <= {24'h000000, flags_reg};
                end else if (rdIdx == `COLL_POS_IDX) begin
                    s_axi_rdata <= {24'h000000, collPos_reg};
                end else if (rdIdx == `ERR_CTRL_IDX) begin
                    s_axi_rdata <= {24'h000000, ctrl_reg};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_DECERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ---- rtl/contactless_error_cfg.svh ----
// register offsets, field positions, reset values and state codes of the error flag block
// assumes inclusion by bare name from the package and the top module
`ifndef CONTACTLESS_ERROR_CFG_SVH
`define CONTACTLESS_ERROR_CFG_SVH
// register indices, byte address is four times the index
`define ERR_FLAGS_IDX 8'h0a
`define COLL_POS_IDX 8'h0d
`define ERR_CTRL_IDX 8'h10
// error flag bit positions
`define BIT_NVM 3'd7
`define BIT_FIFO_WR 3'd6
`define BIT_FIFO_OVL 3'd5
`define BIT_SHORT 3'd4
`define BIT_EMPTY_TX 3'd3
`define BIT_COLL 3'd2
`define BIT_PROT 3'd1
`define BIT_INTEG 3'd0
// control register fields
`define CTRL_MULTI 3'd0
`define CTRL_SUPPRESS 3'd1
`define CTRL_COLL_ERR 3'd3
`define CTRL_RESET 8'h00
`define FLAGS_RESET 8'h00
// collision position register: valid bit on top
`define COLL_VALID 3'd7
// transceiver state codes
`define ST_RX_WAIT 3'h5
`define ST_WAIT_DATA 3'h6
`define ST_RECEIVING 3'h7
// frame length limits
`define MIN_FRAME_BITS 16'h0004
`define MIN_SUPP_BYTES 16'h0003
// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ---- rtl/contactless_error_pkg.sv ----
// types shared by the error flag block and its bench
// assumes the cfg header is on the include path
package contactless_error_pkg;
    `include "contactless_error_cfg.svh"

    // receive decoder events, one-cycle pulses except the counts
    typedef struct packed {
        logic frameEnd;
        logic sofValid;
        logic [15:0] bitCount;
        logic byteReady;
        logic collision;
        logic collisionInEof;
        logic [6:0] collisionPos;
        logic stopBitError;
        logic sofEofError;
        logic byteCountError;
        logic parityError;
        logic crcError;
    } rx_event_s;

    // command unit events
    typedef struct packed {
        logic cmdStart;
        logic recvCmdStart;
        logic transceiveCmd;
        logic nvmCmdDone;
        logic nvmCmdFail;
        logic authActive;
        logic crcTxActive;
        logic txStart;
    } cmd_event_s;
endpackage

// ---- verif/contactless_error_flags_asserts.sv ----
// checker for the error flag block, bound onto its top module
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`include "contactless_error_cfg.svh"
module contactless_error_flags_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [2:0] comState,
    input wire contactless_error_pkg::cmd_event_s cmdEvent,
    input wire contactless_error_pkg::rx_event_s rxEvent,
    input wire logic fifoWrite,
    input wire logic fifoFull,
    input wire logic fifoEmpty,
    input wire logic fifoFlush,
    input wire logic [7:0] errorFlags,
    input wire logic fifoWriteBlock,
    input wire logic fifoStore,
    input wire logic receiveDecoderEnable,
    input wire logic receiveStop,
    input wire logic receiveDoneInterrupt,
    input wire logic frameDiscard,
    input wire logic errorInterruptFlag
);
    // ------
    // helpers and assertions
    // ------
    logic protEv;
    logic rxSet;
    // set wins over clear, so clear checks skip cycles with a protocol, collision, parity or crc event
    assign protEv = rxEvent.stopBitError | rxEvent.sofEofError | rxEvent.byteCountError;
    assign rxSet = protEv | rxEvent.collision | rxEvent.parityError | rxEvent.crcError;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    nvm_flag_a: assert property (clkEn && cmdEvent.nvmCmdDone |=>
        errorFlags[7] == $past(cmdEvent.nvmCmdFail)) else $error("nvm flag wrong");
    wr_viol_a: assert property (clkEn && fifoWrite && (cmdEvent.crcTxActive ||
        cmdEvent.authActive || comState inside {`ST_RX_WAIT, `ST_WAIT_DATA, `ST_RECEIVING})
        |=> errorFlags[6]) else $error("write violation not set");
    ovl_set_a: assert property (clkEn && fifoWrite && fifoFull |=>
        errorFlags[5] && fifoWriteBlock) else $error("overflow not set");
    ovl_hold_a: assert property (clkEn && fifoWriteBlock && !fifoFlush |=>
        fifoWriteBlock && errorFlags[5]) else $error("overflow block dropped");
    short_drop_a: assert property (clkEn && receiveDecoderEnable && rxEvent.frameEnd &&
        rxEvent.sofValid && rxEvent.bitCount < `MIN_FRAME_BITS |=> errorFlags[4] && frameDiscard
        && !receiveDoneInterrupt ##1 receiveDecoderEnable) else $error("short frame handling");
    empty_tx_a: assert property (clkEn && cmdEvent.txStart && fifoEmpty |=>
        errorFlags[3]) else $error("empty transmit not flagged");
    coll_set_a: assert property (clkEn && receiveDecoderEnable && rxEvent.collision &&
        !rxEvent.collisionInEof |=> errorFlags[2]) else $error("collision not set");
    coll_eof_a: assert property (clkEn && rxEvent.collision && rxEvent.collisionInEof &&
        !errorFlags[2] |=> !errorFlags[2]) else $error("eof collision flagged");
    prot_stop_a: assert property (clkEn && protEv |=> errorFlags[1] && receiveStop
        ##1 !receiveDecoderEnable) else $error("protocol error handling");
    prot_nostore_a: assert property (clkEn && protEv && rxEvent.byteReady |=>
        !fifoStore) else $error("byte stored on protocol error");
    integ_set_a: assert property (clkEn && (rxEvent.parityError || rxEvent.crcError) |=>
        errorFlags[0]) else $error("integrity not set");
    rx_clear_a: assert property (clkEn && cmdEvent.recvCmdStart && !rxSet |=>
        (errorFlags & 8'h17) == 8'h00) else $error("receive flags not cleared");
    err_irq_a: assert property (clkEn
        && ((errorFlags & ~$past(errorFlags) & 8'h6b) != 8'h00)
        |-> ##[0:1] errorInterruptFlag) else $error("error interrupt missing");
    // main scenarios reached
    cover property (frameDiscard);
    cover property (fifoWriteBlock && fifoWrite);
    cover property (receiveStop);
    cover property (errorInterruptFlag);
endmodule

bind contactless_error_flags contactless_error_flags_asserts chk (.*);

// ---- verif/contactless_error_flags_tb_top.sv ----
// self-checking bench for the error flag block
// assumes package and cfg header compiled first and the checker bound
`timescale 1ns/1ps
`include "contactless_error_cfg.svh"
module contactless_error_flags_tb_top;
    // ------
    // signals, scoreboards and bus tasks
    // ------
    localparam logic [7:0] FLAGS = `ERR_FLAGS_IDX << 2;
    localparam logic [7:0] POS = `COLL_POS_IDX << 2;
    localparam logic [7:0] CTRL = `ERR_CTRL_IDX << 2;
    localparam logic [1:0] OK = `RESP_OKAY;
    logic sys_clk = 1'h0, rst_n = 1'h0, clkEn = 1'h1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] comState = '0;
    contactless_error_pkg::cmd_event_s cmdEvent = '0;
    contactless_error_pkg::rx_event_s rxEvent = '0;
    logic fifoWrite = 1'h0, fifoFull = 1'h0, fifoEmpty = 1'h0, fifoFlush = 1'h0;
    logic flagsAppended = 1'h0;
    logic [7:0] errorFlags;
    logic fifoWriteBlock, fifoStore, receiveDecoderEnable, receiveStop;
    logic receiveDoneInterrupt, frameDiscard, errorInterruptFlag;
    int error_cnt = 0, compares = 0;
    int irqCnt = 0, stopCnt = 0, storeCnt = 0;
    logic [33:0] readQ[$];
    logic [1:0] writeQ[$];
    logic kindQ[$];

    contactless_error_flags uut (.*);

    always #12.5 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // answers are compared with the oldest note; an unexpected frame pulse never matches
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready)
            check("read", readQ.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", {32'h0, writeQ.pop_front()}, {32'h0, s_axi_bresp});
        if (frameDiscard || receiveDoneInterrupt)
            check("frame", kindQ.size() ? {33'h0, kindQ.pop_front()} : 34'h2,
                  {33'h0, frameDiscard});
        // pulse counts are compared against the rule-derived totals at the end
        if (errorInterruptFlag === 1'h1) irqCnt++;
        if (receiveStop === 1'h1) stopCnt++;
        if (fifoStore === 1'h1) storeCnt++;
    end

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        writeQ.push_back(r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        readQ.push_back({r, d});
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask

    // one-cycle event: command bits, receive events, fifo signals, state
    task automatic ev(input logic [7:0] c, input contactless_error_pkg::rx_event_s r,
                      input logic [4:0] f, input logic [2:0] s);
        @(posedge sys_clk);
        {cmdEvent, rxEvent, comState} <= {c, r, s};
        {fifoWrite, fifoFull, fifoEmpty, fifoFlush, flagsAppended} <= f;
        @(posedge sys_clk);
        {cmdEvent, rxEvent, comState} <= '0;
        {fifoWrite, fifoFull, fifoEmpty, fifoFlush, flagsAppended} <= '0;
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // cuts a hang short; the tests need a small part of this span
    initial begin
        #1000000;
        check("timeout", 34'h0, 34'h1);
        give_verdict();
    end

    // ------
    // tests
    // ------
    initial begin
        logic [31:0] v;
        logic [6:0] p;
        v = $urandom(32'h24df880c);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        v = $urandom();
        wr(FLAGS, v, OK);
        wr(POS, v, OK);
        rd(FLAGS, '0, OK);
        rd(POS, '0, OK);
        rd(CTRL, '0, OK);
        rd(8'h3c, '0, `RESP_DECERR);
        wr(8'h3c, v, `RESP_DECERR);
        wr(CTRL, v, OK);
        rd(CTRL, v & 32'h0b, OK);
        wr(CTRL, '0, OK);
        // a failed nvm command while the clock enable is low must leave no trace
        clkEn <= 1'h0;
        ev(8'h18, '0, '0, '0);
        clkEn <= 1'h1;
        rd(FLAGS, '0, OK);
        ev(8'h18, '0, '0, '0);
        wr(FLAGS, '0, OK);
        rd(FLAGS, 32'h80, OK);
        ev(8'h10, '0, '0, '0);
        rd(FLAGS, '0, OK);
        // each cause of a write violation, then a new command
        for (int i = 0; i < 5; i++) begin
            ev(i == 3 ? 8'h02 : (i == 4 ? 8'h04 : 8'h00), '0, 5'h10, i < 3 ? 3'(5 + i) : 3'h0);
            rd(FLAGS, 32'h40, OK);
            ev(8'h80, '0, '0, '0);
            rd(FLAGS, '0, OK);
        end
        wr(CTRL, 32'h1, OK);
        ev('0, '0, 5'h10, `ST_RECEIVING);
        rd(FLAGS, 32'h40, OK);
        ev('0, '0, 5'h01, '0);
        rd(FLAGS, '0, OK);
        wr(CTRL, '0, OK);
        // overflow then a later write; flush clears
        ev('0, '0, 5'h18, '0);
        ev('0, '0, 5'h10, '0);
        rd(FLAGS, 32'h20, OK);
        ev('0, '0, 5'h02, '0);
        ev(8'h01, '0, 5'h04, '0);
        rd(FLAGS, 32'h08, OK);
        ev(8'h80, '0, '0, '0);
        // receive phase: first collision kept, integrity, short frame
        ev(8'h40, '0, '0, `ST_RX_WAIT);
        p = 7'($urandom());
        ev('0, '{collision: 1'h1, collisionPos: p, default: '0}, '0, `ST_RECEIVING);
        ev('0, '{collision: 1'h1, collisionPos: ~p, default: '0}, '0, `ST_RECEIVING);
        rd(POS, {24'h0, 1'h1, p}, OK);
        ev('0, '{parityError: 1'h1, byteReady: 1'h1, default: '0}, '0, `ST_RECEIVING);
        kindQ.push_back(1'h1);
        ev('0, '{frameEnd: 1'h1, sofValid: 1'h1, bitCount: 16'($urandom_range(3)),
           default: '0}, '0, `ST_RECEIVING);
        rd(FLAGS, 32'h15, OK);
        for (int i = 0; i < 3; i++) begin
            ev(8'h40, '0, '0, `ST_RX_WAIT);
            ev('0, '{byteReady: 1'h1, stopBitError: i == 0, sofEofError: i == 1,
               byteCountError: i == 2, default: '0}, '0, `ST_RECEIVING);
            rd(FLAGS, 32'h02, OK);
        end
        rd(POS, '0, OK);
        // transceive: wait-for-data entry opens and clears the phase
        ev(8'h20, '0, '0, `ST_WAIT_DATA);
        ev('0, '{crcError: 1'h1, default: '0}, '0, `ST_RECEIVING);
        kindQ.push_back(1'h0);
        ev('0, '{frameEnd: 1'h1, sofValid: 1'h1, bitCount: 16'h0018, default: '0}, '0, '0);
        rd(FLAGS, 32'h01, OK);
        ev(8'h20, '0, '0, `ST_WAIT_DATA);
        rd(FLAGS, '0, OK);
        // suppression on, collisions counted as integrity errors
        wr(CTRL, 32'h0a, OK);
        ev(8'h40, '0, '0, `ST_RX_WAIT);
        ev('0, '{collision: 1'h1, collisionInEof: 1'h1, default: '0}, '0, `ST_RECEIVING);
        rd(FLAGS, '0, OK);
        ev('0, '{collision: 1'h1, default: '0}, '0, `ST_RECEIVING);
        rd(FLAGS, 32'h05, OK);
        kindQ.push_back(1'h1);
        ev('0, '{frameEnd: 1'h1, sofValid: 1'h1, bitCount: 16'h0010, default: '0}, '0, '0);
        kindQ.push_back(1'h0);
        ev('0, '{frameEnd: 1'h1, sofValid: 1'h1, bitCount: 16'h0018, default: '0}, '0, '0);
        rd(FLAGS, 32'h05, OK);
        @(posedge sys_clk);
        // fourteen new sets of the interrupting flags, three protocol stops, one stored byte
        check("irq count", 34'h0e, 34'(irqCnt));
        check("stop count", 34'h3, 34'(stopCnt));
        check("store count", 34'h1, 34'(storeCnt));
        check("leftover notes", 34'h0, 34'(readQ.size() + writeQ.size() + kindQ.size()));
        give_verdict();
    end
endmodule
